/* File: mdio_master_with_irq.sv */
// management serial master: register file, interrupt block and link engine
//
// Behaviour
// - link drives pins only while enabled
// - enable write needs nonzero clock divisor
// - phy address field picks target device
// - register address field picks target register
// - operation 01 writes, 10 reads
// - initiate bit starts a transfer
// - ready means enabled, idle, previous done
// - read data bit 16 mirrors ready
// - read data holds phy answer
// - raw status shows sources, resets zero
// - pending is enable and status
// - enable register, one enables, resets zero
// - clear register, one clears bit
// - bit 0 is transfer done, rest reserved
// - no bridging interrupts in this block
// - link registers exist with serial option
`timescale 1ns/100ps
module mdio_master_with_irq
  import mdio_master_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              link_clk,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   irq,
  output logic                   mdc,
  input  wire logic              mdio_in,
  output logic                   mdio_out,
  output logic                   mdio_oe
);

  // ----------------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    LK_IDLE,
    LK_RUN
  } link_phase_t;

  typedef struct packed {
    logic        en_r;
    logic [5:0]  div_r;
    logic [4:0]  phy_r;
    logic [4:0]  rega_r;
    logic [1:0]  kind_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    xfer_cmd_t   cmd_r;
    logic        busy_r;
    logic        ready_r;
    logic        stat_r;
    logic        mask_r;
    logic        irq_r;
    logic [31:0] rdout_r;
    logic        start_tgl_r;
    logic        done_s1_r;
    logic        done_s2_r;
    logic        done_s3_r;
  } host_state_t;

  typedef struct packed {
    link_phase_t phase_r;
    logic        start_s1_r;
    logic        start_s2_r;
    logic        start_s3_r;
    logic        en_s1_r;
    logic        en_s2_r;
    logic        ce_s1_r;
    logic        ce_s2_r;
    logic        in_s1_r;
    logic        in_s2_r;
    logic [5:0]  cnt_r;
    logic [5:0]  bitn_r;
    logic [63:0] shift_r;
    logic [15:0] rx_r;
    logic        wr_r;
    logic        mdc_r;
    logic        oe_r;
    logic        out_r;
    logic        done_tgl_r;
  } link_state_t;

  host_state_t h;
  host_state_t h_nxt;
  link_state_t l;
  link_state_t l_nxt;
  logic        done_evt;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [63:0] build_frame(input xfer_cmd_t c);
    logic wr;
    wr = (c.kind == KIND_WRITE);
    build_frame = {PREAMBLE, FRAME_START, c.kind, c.phy, c.rega,
                   wr ? TURN_WRITE : TURN_IDLE,
                   wr ? c.wdata : DATA_IDLE};
  endfunction : build_frame

  // ----------------------------------------------------------------------
  // host domain
  // ----------------------------------------------------------------------
  always_comb begin
    logic [1:0] kind_w;
    kind_w   = reg_wdata[KIND_MSB:KIND_LSB];
    h_nxt    = h;
    // toggle back from the link marks the end of a frame
    h_nxt.done_s1_r = l.done_tgl_r;
    h_nxt.done_s2_r = h.done_s1_r;
    h_nxt.done_s3_r = h.done_s2_r;
    done_evt = h.done_s2_r ^ h.done_s3_r;
    if (done_evt) begin
      h_nxt.busy_r  = 1'b0;
      // link holds rx stable until the next start, so this word is settled
      h_nxt.rdata_r = l.rx_r;
    end
    if (reg_wr) begin
      if (hit(reg_addr, OFF_LINK_SETUP)) begin
        h_nxt.div_r = reg_wdata[DIV_MSB:DIV_LSB];
        if (reg_wdata[DIV_MSB:DIV_LSB] != DIV_RESET) begin
          h_nxt.en_r = reg_wdata[ENABLE_BIT];
        end
      end
      if (hit(reg_addr, OFF_TRANSFER_CONTROL)) begin
        h_nxt.phy_r  = reg_wdata[PHY_MSB:PHY_LSB];
        h_nxt.rega_r = reg_wdata[REGA_MSB:REGA_LSB];
        h_nxt.kind_r = kind_w;
        // an initiate while not ready is dropped
        if (reg_wdata[INITIATE_BIT] && h.ready_r &&
            (kind_w == KIND_WRITE || kind_w == KIND_READ)) begin
          h_nxt.cmd_r.div   = h.div_r;
          h_nxt.cmd_r.phy   = reg_wdata[PHY_MSB:PHY_LSB];
          h_nxt.cmd_r.rega  = reg_wdata[REGA_MSB:REGA_LSB];
          h_nxt.cmd_r.kind  = kind_w;
          h_nxt.cmd_r.wdata = h.wdata_r;
          h_nxt.busy_r      = 1'b1;
          h_nxt.start_tgl_r = ~h.start_tgl_r;
        end
      end
      if (hit(reg_addr, OFF_OUTGOING_WORD)) begin
        h_nxt.wdata_r = reg_wdata[DATA_MSB:0];
      end
      if (hit(reg_addr, OFF_IRQ_MASK_ON)) begin
        h_nxt.mask_r = reg_wdata[DONE_BIT];
      end
      if (hit(reg_addr, OFF_IRQ_ACKNOWLEDGE) && reg_wdata[DONE_BIT]) begin
        h_nxt.stat_r = 1'b0;
      end
    end
    // disabling aborts the frame at the link, so nothing is left busy
    if (!h_nxt.en_r) begin
      h_nxt.busy_r = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (done_evt) begin
      h_nxt.stat_r = 1'b1;
    end
    h_nxt.ready_r = h_nxt.en_r && !h_nxt.busy_r;
    h_nxt.irq_r   = h.stat_r && h.mask_r;
    if (reg_rd) begin
      h_nxt.rdout_r = 32'h00000000;
      case (1'b1)
        hit(reg_addr, OFF_LINK_SETUP): begin
          h_nxt.rdout_r[ENABLE_BIT]      = h.en_r;
          h_nxt.rdout_r[DIV_MSB:DIV_LSB] = h.div_r;
        end
        hit(reg_addr, OFF_TRANSFER_CONTROL): begin
          h_nxt.rdout_r[PHY_MSB:PHY_LSB]   = h.phy_r;
          h_nxt.rdout_r[REGA_MSB:REGA_LSB] = h.rega_r;
          h_nxt.rdout_r[KIND_MSB:KIND_LSB] = h.kind_r;
          h_nxt.rdout_r[READY_BIT]         = h.ready_r;
        end
        hit(reg_addr, OFF_OUTGOING_WORD): begin
          h_nxt.rdout_r[DATA_MSB:0] = h.wdata_r;
        end
        hit(reg_addr, OFF_INCOMING_WORD): begin
          h_nxt.rdout_r[MIRROR_BIT] = h.ready_r;
          h_nxt.rdout_r[DATA_MSB:0] = h.rdata_r;
        end
        hit(reg_addr, OFF_IRQ_RAW_STATE): begin
          h_nxt.rdout_r[DONE_BIT] = h.stat_r;
        end
        hit(reg_addr, OFF_IRQ_WAITING): begin
          h_nxt.rdout_r[DONE_BIT] = h.stat_r && h.mask_r;
        end
        hit(reg_addr, OFF_IRQ_MASK_ON): begin
          h_nxt.rdout_r[DONE_BIT] = h.mask_r;
        end
        default: begin
          h_nxt.rdout_r = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h <= '0;
    end else if (ce) begin
      h <= h_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------------
  always_comb begin
    l_nxt = l;
    // synchronisers keep running even while frozen
    l_nxt.start_s1_r = h.start_tgl_r;
    l_nxt.start_s2_r = l.start_s1_r;
    l_nxt.en_s1_r    = h.en_r;
    l_nxt.en_s2_r    = l.en_s1_r;
    l_nxt.ce_s1_r    = ce;
    l_nxt.ce_s2_r    = l.ce_s1_r;
    l_nxt.in_s1_r    = mdio_in;
    l_nxt.in_s2_r    = l.in_s1_r;
    if (l.ce_s2_r) begin
      l_nxt.start_s3_r = l.start_s2_r;
      if (!l.en_s2_r) begin
        l_nxt.phase_r = LK_IDLE;
        l_nxt.mdc_r   = 1'b0;
        l_nxt.oe_r    = 1'b0;
        l_nxt.out_r   = 1'b0;
        l_nxt.cnt_r   = 6'h00;
      end else begin
        case (l.phase_r)
          LK_IDLE: begin
            // command word is quiet while busy, safe to sample here
            if (l.start_s2_r ^ l.start_s3_r) begin
              l_nxt.phase_r = LK_RUN;
              l_nxt.shift_r = build_frame(h.cmd_r);
              l_nxt.wr_r    = (h.cmd_r.kind == KIND_WRITE);
              l_nxt.bitn_r  = 6'h00;
              l_nxt.cnt_r   = 6'h00;
              l_nxt.mdc_r   = 1'b0;
              l_nxt.oe_r    = 1'b1;
              l_nxt.out_r   = l_nxt.shift_r[63];
            end
          end
          LK_RUN: begin
            if (l.cnt_r == 6'(h.cmd_r.div - 6'h01)) begin
              l_nxt.cnt_r = 6'h00;
              l_nxt.mdc_r = ~l.mdc_r;
              if (!l.mdc_r) begin
                // sample on the rising edge of the serial clock
                l_nxt.rx_r = {l.rx_r[14:0], l.in_s2_r};
              end else if (l.bitn_r == LAST_BIT) begin
                l_nxt.phase_r    = LK_IDLE;
                l_nxt.oe_r       = 1'b0;
                l_nxt.out_r      = 1'b0;
                l_nxt.done_tgl_r = ~l.done_tgl_r;
              end else begin
                l_nxt.bitn_r  = 6'(l.bitn_r + 6'h01);
                l_nxt.shift_r = {l.shift_r[62:0], 1'b0};
                l_nxt.out_r   = l.shift_r[62];
                // a read releases the line at the turnaround
                l_nxt.oe_r    = l.wr_r || (6'(l.bitn_r + 6'h01) < READ_DRIVE);
              end
            end else begin
              l_nxt.cnt_r = 6'(l.cnt_r + 6'h01);
            end
          end
          default: begin
            l_nxt.phase_r = LK_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      l <= '0;
    end else begin
      l <= l_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = h.rdout_r;
  assign irq       = h.irq_r;
  assign mdc       = l.mdc_r;
  assign mdio_out  = l.out_r;
  assign mdio_oe   = l.oe_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  ready_needs_en_a: assert property (@(posedge clk) disable iff (!resetn)
    h.ready_r |-> (h.en_r && !h.busy_r))
    else $error("ready high while disabled or busy");

  en_div_nonzero_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(h.en_r) |-> (h.div_r != DIV_RESET))
    else $error("link enabled with zero divisor");

  start_busy_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && reg_wr && hit(reg_addr, OFF_TRANSFER_CONTROL) && reg_wdata[INITIATE_BIT]
     && h.ready_r && reg_wdata[KIND_MSB:KIND_LSB] == KIND_READ)
    |=> (h.busy_r && !h.ready_r && h.cmd_r.kind == KIND_READ))
    else $error("accepted initiate did not start a transfer");

  pend_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(ce) |-> (irq == ($past(h.stat_r) && $past(h.mask_r))))
    else $error("pending output not status and enable");

  done_sets_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && done_evt) |=> (h.stat_r && h.ready_r == h.en_r))
    else $error("transfer end did not set status");

  clear_bit_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && !done_evt && reg_wr && hit(reg_addr, OFF_IRQ_ACKNOWLEDGE) && reg_wdata[DONE_BIT])
    |=> !h.stat_r)
    else $error("clear write left status set");

  ready_mirror_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && reg_rd && hit(reg_addr, OFF_INCOMING_WORD))
    |=> (reg_rdata[MIRROR_BIT] == $past(h.ready_r) && reg_rdata[31:17] == 15'h0000))
    else $error("read data bit 16 differs from ready");

  irq_reserved_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && reg_rd && (hit(reg_addr, OFF_IRQ_RAW_STATE) || hit(reg_addr, OFF_IRQ_MASK_ON)))
    |=> (reg_rdata[31:1] == 31'h00000000))
    else $error("reserved interrupt bits read nonzero");

  link_idle_a: assert property (@(posedge link_clk) disable iff (!resetn)
    (l.ce_s2_r && !l.en_s2_r) |=> (!mdio_oe && !mdc)[*2])
    else $error("link active while disabled");

  frame_data_a: assert property (@(posedge link_clk) disable iff (!resetn)
    (l.ce_s2_r && l.en_s2_r && l.phase_r == LK_IDLE && (l.start_s2_r ^ l.start_s3_r)
     && h.cmd_r.kind == KIND_WRITE)
    |=> (l.shift_r[15:0] == h.cmd_r.wdata && l.shift_r[22:18] == h.cmd_r.rega
         && l.shift_r[27:23] == h.cmd_r.phy && mdio_oe))
    else $error("write frame does not carry command fields");

  kind_refused_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && reg_wr && hit(reg_addr, OFF_TRANSFER_CONTROL) && reg_wdata[INITIATE_BIT]
     && reg_wdata[KIND_MSB:KIND_LSB] != KIND_WRITE && reg_wdata[KIND_MSB:KIND_LSB] != KIND_READ)
    |=> (h.start_tgl_r == $past(h.start_tgl_r)))
    else $error("initiate with reserved operation started a transfer");

  mask_write_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && reg_wr && hit(reg_addr, OFF_IRQ_MASK_ON))
    |=> ({31'h00000000, h.mask_r} == ($past(reg_wdata) & 32'h00000001)))
    else $error("enable register did not take written bit");

  word_write_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && reg_wr && hit(reg_addr, OFF_OUTGOING_WORD))
    |=> ({16'h0000, h.wdata_r} == ($past(reg_wdata) & 32'h0000FFFF)))
    else $error("outgoing word did not take written data");

  pend_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && reg_rd && hit(reg_addr, OFF_IRQ_WAITING))
    |=> (reg_rdata == {31'h00000000, ($past(h.stat_r) && $past(h.mask_r))}))
    else $error("pending read differs from status and enable");

  read_release_a: assert property (@(posedge link_clk) disable iff (!resetn)
    (l.phase_r == LK_RUN && !l.wr_r && l.bitn_r >= READ_DRIVE) |-> !mdio_oe)
    else $error("read frame still drives the line after turnaround");

endmodule : mdio_master_with_irq

/* File: mdio_master_pkg.sv */
// constants, register map and carrier types for the management serial master
package mdio_master_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_LINK_SETUP       = 12'h500;
  localparam logic [11:0] OFF_TRANSFER_CONTROL = 12'h504;
  localparam logic [11:0] OFF_OUTGOING_WORD    = 12'h508;
  localparam logic [11:0] OFF_INCOMING_WORD    = 12'h50C;
  localparam logic [11:0] OFF_IRQ_RAW_STATE    = 12'h600;
  localparam logic [11:0] OFF_IRQ_WAITING      = 12'h610;
  localparam logic [11:0] OFF_IRQ_MASK_ON      = 12'h620;
  localparam logic [11:0] OFF_IRQ_ACKNOWLEDGE  = 12'h630;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned ENABLE_BIT   = 6;
  localparam int unsigned DIV_MSB      = 5;
  localparam int unsigned DIV_LSB      = 0;
  localparam int unsigned PHY_MSB      = 28;
  localparam int unsigned PHY_LSB      = 24;
  localparam int unsigned REGA_MSB     = 20;
  localparam int unsigned REGA_LSB     = 16;
  localparam int unsigned KIND_MSB     = 15;
  localparam int unsigned KIND_LSB     = 14;
  localparam int unsigned INITIATE_BIT = 11;
  localparam int unsigned READY_BIT    = 7;
  localparam int unsigned MIRROR_BIT   = 16;
  localparam int unsigned DATA_MSB     = 15;
  localparam int unsigned DONE_BIT     = 0;

  // ----------------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]  KIND_WRITE  = 2'h1;
  localparam logic [1:0]  KIND_READ   = 2'h2;
  localparam logic [5:0]  DIV_RESET   = 6'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;

  // ----------------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------------
  localparam logic [31:0] PREAMBLE    = 32'hFFFFFFFF;
  localparam logic [1:0]  FRAME_START = 2'h1;
  localparam logic [1:0]  TURN_WRITE  = 2'h2;
  localparam logic [1:0]  TURN_IDLE   = 2'h3;
  localparam logic [15:0] DATA_IDLE   = 16'hFFFF;
  localparam logic [5:0]  LAST_BIT    = 6'h3F;
  localparam logic [5:0]  READ_DRIVE  = 6'h2E;

  typedef struct packed {
    logic [5:0]  div;
    logic [4:0]  phy;
    logic [4:0]  rega;
    logic [1:0]  kind;
    logic [15:0] wdata;
  } xfer_cmd_t;

endpackage : mdio_master_pkg

/* File: mdio_phy_model.sv */
// partner model: one phy answering on the management serial bus
`timescale 1ns/100ps
module mdio_phy_model
  import mdio_master_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h05
) (
  input  wire logic        mdc,
  input  wire logic        mdio_wire,
  input  wire logic        master_oe,
  input  wire logic [7:0]  lag_ns,
  output logic             phy_oe,
  output logic             phy_out,
  output logic             frame_ok,
  output logic [4:0]       last_phy,
  output logic [4:0]       last_reg,
  output logic [1:0]       last_kind,
  output logic [15:0]      last_data,
  output logic [7:0]       n_frames
);
  logic [63:0] sh;
  logic [15:0] mem [32];
  logic [15:0] dout;
  logic        rd_hit;
  int          cnt;

  initial begin
    {phy_oe, rd_hit, frame_ok, last_phy, last_reg, last_kind, last_data, n_frames} = '0;
    phy_out = 1'h1;
    cnt     = 0;
    for (int i = 0; i < 32; i++) begin
      mem[i] = 16'h3C00 + 16'(i);
    end
  end

  // ----------------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------------
  // a new frame restarts the count and drops any stale drive left by an abort
  always @(posedge master_oe) begin
    cnt    = 0;
    rd_hit = 1'h0;
    phy_oe = 1'h0;
  end

  always @(posedge mdc) begin
    sh  = {sh[62:0], mdio_wire};
    cnt = cnt + 1;
    if (cnt == 46) begin
      rd_hit = (sh[11:10] == KIND_READ) && (sh[9:5] == PHY_ADDR);
      dout   = mem[sh[4:0]];
    end
    // drive after the rising edge, lag must stay below half an mdc period
    #(lag_ns);
    if (rd_hit && cnt == 47) begin
      phy_oe  = 1'h1;
      phy_out = 1'h0;
    end else if (rd_hit && cnt >= 48 && cnt < 64) begin
      phy_out = dout[63-cnt];
    end else if (cnt == 64) begin
      phy_oe   = 1'h0;
      rd_hit   = 1'h0;
      frame_ok = (sh[63:32] == PREAMBLE) && (sh[31:30] == FRAME_START)
                 && (sh[29:28] != KIND_WRITE || sh[17:16] == TURN_WRITE);
      {last_kind, last_phy, last_reg, last_data} = {sh[29:18], sh[15:0]};
      n_frames = n_frames + 8'h01;
      if (sh[29:28] == KIND_WRITE && sh[27:23] == PHY_ADDR) begin
        mem[sh[22:18]] = sh[15:0];
      end
    end
  end
endmodule : mdio_phy_model

/* File: test_mdio_master_with_irq.sv */
// self-checking testbench for the management serial master
`timescale 1ns/100ps
module test_mdio_master_with_irq
  import mdio_master_pkg::*;
();
  logic              clk, resetn, ce, link_clk, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, v;
  logic              irq, mdc, mdio_in, mdio_out, mdio_oe, phy_oe, phy_out, frame_ok;
  logic [4:0]        last_phy, last_reg;
  logic [1:0]        last_kind;
  logic [15:0]       last_data;
  logic [7:0]        n_frames, lag_ns, nf;
  int                n_mismatch, compares;
  logic [11:0]       offs [9] = '{OFF_LINK_SETUP, OFF_TRANSFER_CONTROL, OFF_OUTGOING_WORD, OFF_INCOMING_WORD,
                                  OFF_IRQ_RAW_STATE, OFF_IRQ_WAITING, OFF_IRQ_MASK_ON, OFF_IRQ_ACKNOWLEDGE, 12'h700};
  logic [4:0]        rphy [3] = '{5'h05, 5'h05, 5'h09};
  logic [4:0]        rreg [3] = '{5'h1A, 5'h03, 5'h03};
  logic [7:0]        rlag [3] = '{8'h01, 8'h14, 8'h01};
  logic [15:0]       rexp [3] = '{16'hA5C3, 16'h3C03, 16'hFFFF};

  // pull-up on the shared line: nobody driving reads as one
  assign mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'h1);

  mdio_master_with_irq mdio_master_with_irq_i (.clk(clk), .resetn(resetn), .ce(ce), .link_clk(link_clk),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq(irq), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  mdio_phy_model #(.PHY_ADDR(5'h05)) mdio_phy_model_i (.mdc(mdc), .mdio_wire(mdio_in), .master_oe(mdio_oe),
    .lag_ns(lag_ns), .phy_oe(phy_oe), .phy_out(phy_out), .frame_ok(frame_ok), .last_phy(last_phy),
    .last_reg(last_reg), .last_kind(last_kind), .last_data(last_data), .n_frames(n_frames));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // phase offset keeps the link clock unrelated to the host clock
  initial begin
    link_clk = 1'h0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  function automatic logic [31:0] word(input logic [4:0] p, input logic [4:0] r, input logic [1:0] k,
                                       input logic go, input logic rdy);
    return {3'h0, p, 3'h0, r, k, 2'h0, go, 3'h0, rdy, 7'h0};
  endfunction : word

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 reg_wr = 1'h1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'h0;
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    #1 reg_rd = 1'h1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'h0;
    chk(reg_rdata, exp);
  endtask : rchk

  // bounded poll of the mirrored ready bit, reading as software would
  task automatic wait_ready();
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1 reg_rd = 1'h1;
      reg_addr = OFF_INCOMING_WORD;
      @(posedge clk);
      #1 reg_rd = 1'h0;
      if (reg_rdata[MIRROR_BIT] === 1'h1) return;
    end
    n_mismatch++;
    $display("wrong value at %0t: ready never came", $time);
    results();
  endtask : wait_ready

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {n_mismatch, compares} = '0;
    ce     = 1'h1;
    lag_ns = 8'h01;
    repeat (5) @(posedge clk);
    #1 resetn = 1'h1;
    foreach (offs[i]) rchk(offs[i], 32'h0);
    wr(OFF_TRANSFER_CONTROL, word(5'h05, 5'h01, KIND_READ, 1'h1, 1'h0));
    repeat (100) @(posedge clk);
    chk({22'h0, mdc, mdio_oe, n_frames}, 32'h0);
    wr(OFF_LINK_SETUP, 32'h40);
    rchk(OFF_LINK_SETUP, 32'h0);
    wr(OFF_LINK_SETUP, 32'h42);
    rchk(OFF_LINK_SETUP, 32'h42);
    wait_ready();
    ce = 1'h0;
    wr(OFF_OUTGOING_WORD, 32'h1234);
    ce = 1'h1;
    rchk(OFF_OUTGOING_WORD, 32'h0);
    wr(OFF_IRQ_MASK_ON, 32'hFFFFFFFF);
    rchk(OFF_IRQ_MASK_ON, 32'h1);
    wr(OFF_OUTGOING_WORD, 32'hFFFFA5C3);
    rchk(OFF_OUTGOING_WORD, 32'h0000A5C3);
    wr(OFF_TRANSFER_CONTROL, word(5'h05, 5'h1A, KIND_WRITE, 1'h1, 1'h0));
    rchk(OFF_INCOMING_WORD, 32'h0);
    wait_ready();
    chk({3'h0, frame_ok, last_phy, last_reg, last_kind, last_data},
        {3'h0, 1'h1, 5'h05, 5'h1A, KIND_WRITE, 16'hA5C3});
    rchk(OFF_TRANSFER_CONTROL, word(5'h05, 5'h1A, KIND_WRITE, 1'h0, 1'h1));
    rchk(OFF_IRQ_RAW_STATE, 32'h1);
    rchk(OFF_IRQ_WAITING, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_ACKNOWLEDGE, 32'h0);
    rchk(OFF_IRQ_RAW_STATE, 32'h1);
    wr(OFF_IRQ_ACKNOWLEDGE, 32'h1);
    rchk(OFF_IRQ_RAW_STATE, 32'h0);
    rchk(OFF_IRQ_WAITING, 32'h0);
    rchk(OFF_IRQ_ACKNOWLEDGE, 32'h0);
    // masked source still shows raw status but never pends
    wr(OFF_IRQ_MASK_ON, 32'h0);
    for (int i = 0; i < 3; i++) begin
      lag_ns = rlag[i];
      wr(OFF_TRANSFER_CONTROL, word(rphy[i], rreg[i], KIND_READ, 1'h1, 1'h0));
      wait_ready();
      chk({30'h0, last_kind}, {30'h0, KIND_READ});
      rchk(OFF_INCOMING_WORD, {15'h0, 1'h1, rexp[i]});
    end
    rchk(OFF_IRQ_RAW_STATE, 32'h1);
    rchk(OFF_IRQ_WAITING, 32'h0);
    chk({31'h0, irq}, 32'h0);
    nf = n_frames;
    wr(OFF_TRANSFER_CONTROL, word(5'h05, 5'h02, 2'h0, 1'h1, 1'h0));
    wr(OFF_TRANSFER_CONTROL, word(5'h05, 5'h02, 2'h3, 1'h1, 1'h0));
    repeat (200) @(posedge clk);
    chk({24'h0, n_frames}, {24'h0, nf});
    wr(OFF_IRQ_ACKNOWLEDGE, 32'h1);
    // disabling mid-frame must abandon the transfer with no completion
    wr(OFF_TRANSFER_CONTROL, word(5'h05, 5'h04, KIND_WRITE, 1'h1, 1'h0));
    repeat (100) @(posedge clk);
    wr(OFF_LINK_SETUP, 32'h02);
    repeat (20) @(posedge clk);
    chk({22'h0, mdc, mdio_oe, n_frames}, {24'h0, nf});
    rchk(OFF_IRQ_RAW_STATE, 32'h0);
    rchk(OFF_TRANSFER_CONTROL, word(5'h05, 5'h04, KIND_WRITE, 1'h0, 1'h0));
    results();
  end
endmodule : test_mdio_master_with_irq
